/* File: rtl/xcvr_reconfig_consts.svh */
`ifndef XCVR_RECONFIG_CONSTS_SVH
`define XCVR_RECONFIG_CONSTS_SVH

// Management register word addresses, one 32-bit register each
`define REG_PMA_CHAN 7'h08
`define REG_PMA_CSR 7'h0A
`define REG_PMA_OFS 7'h0B
`define REG_PMA_DATA 7'h0C
`define REG_EYE_CSR 7'h12
`define REG_DFE_CSR 7'h1A
`define REG_DCD_CSR 7'h22
`define REG_AEQ_CSR 7'h2A
`define REG_ATX_CSR 7'h32
`define REG_STR_CSR 7'h3A
`define REG_STR_BASE 7'h3C
`define REG_PLL_CSR 7'h42

// Control and status bit positions
`define CSR_WRITE_BIT 0
`define CSR_READ_BIT 1
`define CSR_START_BIT 0
`define CSR_BUSY_BIT 8
`define CSR_ERR_BIT 9

// Field widths and reset values
`define CHAN_W 10
`define OFS_W 6
`define DATA_W 7
`define RDATA_RST 32'h0000_0000
`define IMG_BASE_RST 32'h0000_0000

// Duty-cycle calibration threshold, 4.9152 Gbps in kbit/s
`define DCD_MIN_RATE_KBPS 4915200

// Image words are 16 bits, addressed by byte
`define IMG_ADDR_STEP 32'h0000_0002

`endif

/* File: rtl/xcvr_reconfig_pkg.sv */
package xcvr_reconfig_pkg;

  // Command carried on each 70-bit lane update bus
  typedef struct packed {
    logic wr;
    logic rd;
    logic ocal;
    logic dcd;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [33:0] rsvd;
  } lane_cmd_t;

  // Answer carried on each 46-bit return bus
  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
    logic [27:0] rsvd;
  } lane_ret_t;

  typedef enum logic [3:0] {
    S_OCAL, S_DCD_WAIT, S_DCD, S_IDLE, S_PMA_WR, S_PMA_RD, S_STREAM, S_STR_WR
  } seq_state_t;

  typedef enum logic [1:0] {
    F_IDLE, F_REQ, F_HOLD
  } fetch_state_t;

endpackage : xcvr_reconfig_pkg

/* File: rtl/lane_port.sv */
`timescale 1ns/1ps
`include "xcvr_reconfig_consts.svh"

module lane_port
  import xcvr_reconfig_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic sel,
  input wire lane_cmd_t cmd,
  output lane_cmd_t lane_out,
  input wire lane_ret_t lane_in,
  output logic ack,
  output logic err,
  output logic [15:0] rdata
);

  typedef struct packed {
    lane_cmd_t cmd;
  } lane_reg_t;

  lane_reg_t s_q;
  lane_reg_t s_d;
  logic active;

  // Bus carries the command only while selected; own ack drops it at once,
  // so the lane is clear when the sequencer returns to idle
  always_comb begin
    s_d = s_q;
    s_d.cmd = (sel && !clr && !ack) ? cmd : '0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Answer counts only once our own command is on the wires
  assign active = s_q.cmd.wr | s_q.cmd.rd | s_q.cmd.ocal | s_q.cmd.dcd;
  assign lane_out = s_q.cmd;
  assign ack = sel & active & lane_in.ack;
  assign err = ack & lane_in.err;
  assign rdata = ack ? lane_in.rdata : 16'h0000;

endmodule : lane_port

/* File: rtl/image_fetch.sv */
`timescale 1ns/1ps
`include "xcvr_reconfig_consts.svh"

module image_fetch
  import xcvr_reconfig_pkg::*;
#(
  parameter logic [15:0] IMG_WORDS = 16'h0010
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic start,
  input wire logic [31:0] base,
  input wire logic take,
  output logic [31:0] img_address,
  output logic img_read,
  input wire logic [15:0] img_readdata,
  input wire logic img_waitrequest,
  output logic word_valid,
  output logic [15:0] word,
  output logic busy
);

  if (IMG_WORDS == 16'h0000 || IMG_WORDS[0]) begin : g_bad_words
    $error("IMG_WORDS must be even and non-zero");
  end

  typedef struct packed {
    fetch_state_t st;
    logic [31:0] addr;
    logic [15:0] left;
    logic [15:0] word;
  } fetch_reg_t;

  fetch_reg_t s_q;
  fetch_reg_t s_d;

  // One read at a time; next read waits until the word is taken
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      F_IDLE: begin
        if (start) begin
          s_d.st = F_REQ;
          s_d.addr = base;
          s_d.left = IMG_WORDS;
        end
      end
      F_REQ: begin
        if (!img_waitrequest) begin
          s_d.word = img_readdata;
          s_d.addr = s_q.addr + `IMG_ADDR_STEP;
          s_d.left = s_q.left - 16'h0001;
          s_d.st = F_HOLD;
        end
      end
      F_HOLD: begin
        if (take) begin
          s_d.st = (s_q.left == 16'h0000) ? F_IDLE : F_REQ;
        end
      end
      default: s_d.st = F_IDLE;
    endcase
    if (clr) begin
      s_d.st = F_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: F_IDLE, addr: 32'h0000_0000, left: 16'h0000, word: 16'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  // Address and strobe are held steady while the memory stalls
  assign img_address = s_q.addr;
  assign img_read = (s_q.st == F_REQ);
  assign word_valid = (s_q.st == F_HOLD);
  assign word = s_q.word;
  assign busy = (s_q.st != F_IDLE);

endmodule : image_fetch

/* File: rtl/xcvr_reconfig_ctrl.sv */
`timescale 1ns/1ps
`include "xcvr_reconfig_consts.svh"

// Behaviour
// - Image fetch drives a 32-bit byte address.
// - Read strobe requests a word; 16-bit read data accepted.
// - Chain input, with status option, defers duty-cycle calibration while others run.
// - Transmit calibration busy feeds the next controller's chain input.
// - Duty-cycle calibration only for line rates at or above 4.9152 Gbps.
// - 70-bit update bus out, 46-bit return bus in, per interface.
// - One interface per channel and one per TX PLL.
// - Update-in-progress high while any operation runs; no new start meanwhile.
// - Each feature busy bit mirrors the update-in-progress output.
// - TX calibration busy high in initial calibration and reset, not manual.
// - RX calibration busy high in power-up offset cancellation and reset, not in duty-cycle calibration.
// - Calibration busy ports live only with the status option on.
// - Offset cancellation always present, runs once after power-up unasked.
// - Enabled duty-cycle calibration runs once during power-up.
// - Grouping lists interface counts per PHY; empty means one PHY.
// - Optional feature blocks exist only when their parameter is on.
// - Registers reached through a memory-mapped management slave.
// - Management reset active high, level, holds whole controller.
// - Management address decoded as a word address, one 32-bit register each.
module xcvr_reconfig_ctrl
  import xcvr_reconfig_pkg::*;
#(
  parameter int NUM_CH = 1,
  parameter int NUM_PLL = 1,
  parameter logic [31:0] IF_GROUPS = 32'h0000_0000,
  parameter int LINE_RATE_KBPS = 6144000,
  parameter bit EN_DCD = 1'b1,
  parameter bit EN_CAL_STATUS = 1'b1,
  parameter bit EN_PLL_CAL = 1'b0,
  parameter bit EN_EYE = 1'b0,
  parameter bit EN_DFE = 1'b0,
  parameter bit EN_AEQ = 1'b0,
  parameter bit EN_CHAN_PLL_RECONF = 1'b1,
  parameter bit EN_PLL_RECONF = 1'b0,
  parameter logic [15:0] IMG_WORDS = 16'h0010,
  localparam int NUM_IF = NUM_CH + NUM_PLL
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic mgmt_rst_reset,
  input wire logic [6:0] mgmt_address,
  input wire logic [31:0] mgmt_writedata,
  output logic [31:0] mgmt_readdata,
  input wire logic mgmt_write,
  input wire logic mgmt_read,
  output logic [31:0] img_address,
  output logic img_read,
  input wire logic [15:0] img_readdata,
  input wire logic img_waitrequest,
  output logic [NUM_IF*70-1:0] lane_update_bus_out,
  input wire logic [NUM_IF*46-1:0] lane_return_bus_in,
  output logic reconfig_busy,
  output logic tx_cal_busy,
  output logic rx_cal_busy,
  input wire logic cal_busy_in
);

  // Sum of the per-PHY interface counts, one byte each
  function automatic int group_sum(logic [31:0] g);
    int s;
    s = 0;
    for (int k = 0; k < 4; k++) begin
      s = s + int'(g[k*8 +: 8]);
    end
    return s;
  endfunction : group_sum

  // Elaboration checks on the options
  if (NUM_CH < 1 || NUM_PLL < 0 || NUM_IF > 1024) begin : g_bad_count
    $error("NUM_CH must be at least 1 and NUM_IF at most 1024");
  end
  if (IF_GROUPS != 32'h0000_0000 && group_sum(IF_GROUPS) != NUM_IF) begin : g_bad_group
    $error("IF_GROUPS counts must add up to NUM_IF");
  end

  localparam bit DCD_ON = EN_DCD && (LINE_RATE_KBPS >= `DCD_MIN_RATE_KBPS);
  localparam bit STR_ON = EN_CHAN_PLL_RECONF || EN_PLL_RECONF;
  localparam logic [9:0] LAST_CH = 10'(NUM_CH - 1);
  localparam logic [9:0] IF_COUNT = 10'(NUM_IF);

  typedef struct packed {
    seq_state_t st;
    logic init;
    logic [9:0] idx;
    logic [9:0] chan;
    logic [5:0] ofs;
    logic [6:0] data;
    logic err;
    logic [31:0] img_base;
    logic [15:0] img_ofs;
    logic [15:0] img_dat;
    logic img_have;
    logic [31:0] rdata;
  } ctrl_reg_t;

  ctrl_reg_t s_q;
  ctrl_reg_t s_d;
  logic [1:0] rst_sync_q;
  logic rst_n_i;
  logic clr;
  logic cmd_act;
  lane_cmd_t cmd;
  logic [NUM_IF-1:0] ack_vec;
  logic [NUM_IF-1:0] err_vec;
  logic [15:0] rdata_vec [NUM_IF];
  logic any_ack;
  logic any_err;
  logic [15:0] ret_rdata;
  logic chain_busy;
  logic fetch_start;
  logic fetch_take;
  logic word_valid;
  logic [15:0] word;
  logic fetch_busy;
  logic wr_pma_csr;
  logic wr_str_csr;
  logic wr_dcd_csr;
  logic [31:0] busy_word;

  // Asynchronous reset released through two flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_i = rst_sync_q[1];
  // Level reset from management holds every state machine
  assign clr = mgmt_rst_reset;

  // Chain input is ignored when the status option is off
  assign chain_busy = EN_CAL_STATUS ? cal_busy_in : 1'b0;

  // Command issued on the lane of the current index
  always_comb begin
    cmd = '0;
    cmd_act = 1'b1;
    case (s_q.st)
      S_OCAL: cmd.ocal = 1'b1;
      S_DCD: cmd.dcd = 1'b1;
      S_PMA_WR: begin
        cmd.wr = 1'b1;
        cmd.addr = {10'h000, s_q.ofs};
        cmd.wdata = {9'h000, s_q.data};
      end
      S_PMA_RD: begin
        cmd.rd = 1'b1;
        cmd.addr = {10'h000, s_q.ofs};
      end
      S_STR_WR: begin
        cmd.wr = 1'b1;
        cmd.addr = s_q.img_ofs;
        cmd.wdata = s_q.img_dat;
      end
      default: cmd_act = 1'b0;
    endcase
  end

  // One lane port per channel and per TX PLL
  for (genvar i = 0; i < NUM_IF; i++) begin : g_lane
    lane_port u_lane (
      .ref_clk(ref_clk),
      .rst_n(rst_n_i),
      .clr(clr),
      .sel(cmd_act && (s_q.idx == 10'(i))),
      .cmd(cmd),
      .lane_out(lane_update_bus_out[i*70 +: 70]),
      .lane_in(lane_return_bus_in[i*46 +: 46]),
      .ack(ack_vec[i]),
      .err(err_vec[i]),
      .rdata(rdata_vec[i])
    );
  end

  // Only the selected lane answers, so OR is a mux
  always_comb begin
    ret_rdata = 16'h0000;
    for (int i = 0; i < NUM_IF; i++) begin
      ret_rdata = ret_rdata | rdata_vec[i];
    end
  end
  assign any_ack = |ack_vec;
  assign any_err = |err_vec;

  // Configuration image fetcher
  image_fetch #(
    .IMG_WORDS(IMG_WORDS)
  ) u_fetch (
    .ref_clk(ref_clk),
    .rst_n(rst_n_i),
    .clr(clr),
    .start(fetch_start),
    .base(s_q.img_base),
    .take(fetch_take),
    .img_address(img_address),
    .img_read(img_read),
    .img_readdata(img_readdata),
    .img_waitrequest(img_waitrequest),
    .word_valid(word_valid),
    .word(word),
    .busy(fetch_busy)
  );

  // Trigger writes, acted on only when idle
  assign wr_pma_csr = mgmt_write && (mgmt_address == `REG_PMA_CSR);
  assign wr_str_csr = STR_ON && mgmt_write && (mgmt_address == `REG_STR_CSR);
  assign wr_dcd_csr = DCD_ON && mgmt_write && (mgmt_address == `REG_DCD_CSR);
  assign fetch_start = (s_q.st == S_IDLE) && wr_str_csr && mgmt_writedata[`CSR_START_BIT];
  assign fetch_take = (s_q.st == S_STREAM) && word_valid;
  assign busy_word = {22'h000000, s_q.err, reconfig_busy, 8'h00};

  // Sequencer and register file
  always_comb begin
    s_d = s_q;
    // Configuration writes
    if (mgmt_write && mgmt_address == `REG_PMA_CHAN) begin
      s_d.chan = mgmt_writedata[`CHAN_W-1:0];
    end
    if (mgmt_write && mgmt_address == `REG_PMA_OFS) begin
      s_d.ofs = mgmt_writedata[`OFS_W-1:0];
    end
    if (mgmt_write && mgmt_address == `REG_PMA_DATA) begin
      s_d.data = mgmt_writedata[`DATA_W-1:0];
    end
    if (STR_ON && mgmt_write && mgmt_address == `REG_STR_BASE) begin
      s_d.img_base = mgmt_writedata;
    end
    case (s_q.st)
      // Power-up offset cancellation, channels only
      S_OCAL: begin
        if (any_ack) begin
          if (s_q.idx == LAST_CH) begin
            s_d.idx = 10'h000;
            s_d.st = DCD_ON ? S_DCD_WAIT : S_IDLE;
            s_d.init = DCD_ON;
          end else begin
            s_d.idx = s_q.idx + 10'h001;
          end
        end
      end
      // Wait for calibration elsewhere on this side
      S_DCD_WAIT: begin
        if (!chain_busy) begin
          s_d.st = S_DCD;
        end
      end
      S_DCD: begin
        if (any_ack) begin
          if (s_q.idx == LAST_CH) begin
            s_d.idx = 10'h000;
            s_d.st = S_IDLE;
            s_d.init = 1'b0;
          end else begin
            s_d.idx = s_q.idx + 10'h001;
            s_d.st = S_DCD_WAIT;
          end
        end
      end
      // New operations accepted only here
      S_IDLE: begin
        if (wr_pma_csr && (mgmt_writedata[`CSR_WRITE_BIT] || mgmt_writedata[`CSR_READ_BIT])) begin
          s_d.err = (s_q.chan >= IF_COUNT);
          s_d.idx = s_q.chan;
          if (s_q.chan < IF_COUNT) begin
            s_d.st = mgmt_writedata[`CSR_WRITE_BIT] ? S_PMA_WR : S_PMA_RD;
          end
        end else if (fetch_start) begin
          s_d.err = (s_q.chan >= IF_COUNT);
          s_d.idx = s_q.chan;
          s_d.img_have = 1'b0;
          s_d.st = S_STREAM;
        end else if (wr_dcd_csr && mgmt_writedata[`CSR_START_BIT]) begin
          // Manual rerun leaves the calibration busy outputs low
          s_d.idx = 10'h000;
          s_d.init = 1'b0;
          s_d.st = S_DCD_WAIT;
        end
      end
      S_PMA_WR: begin
        if (any_ack) begin
          s_d.err = any_err;
          s_d.st = S_IDLE;
        end
      end
      S_PMA_RD: begin
        if (any_ack) begin
          s_d.err = any_err;
          s_d.data = ret_rdata[`DATA_W-1:0];
          s_d.st = S_IDLE;
        end
      end
      // Image words pair as offset then data
      S_STREAM: begin
        if (word_valid && !s_q.img_have) begin
          s_d.img_ofs = word;
          s_d.img_have = 1'b1;
        end else if (word_valid) begin
          s_d.img_dat = word;
          s_d.img_have = 1'b0;
          s_d.st = s_q.err ? S_STREAM : S_STR_WR;
        end else if (!fetch_busy) begin
          s_d.st = S_IDLE;
        end
      end
      S_STR_WR: begin
        if (any_ack) begin
          s_d.err = any_err;
          s_d.st = S_STREAM;
        end
      end
      default: s_d.st = S_IDLE;
    endcase
    // Read data registered, one cycle after the read strobe
    if (mgmt_read) begin
      case (mgmt_address)
        `REG_PMA_CHAN: s_d.rdata = {22'h000000, s_q.chan};
        `REG_PMA_CSR: s_d.rdata = busy_word;
        `REG_PMA_OFS: s_d.rdata = {26'h0000000, s_q.ofs};
        `REG_PMA_DATA: s_d.rdata = {25'h0000000, s_q.data};
        `REG_EYE_CSR: s_d.rdata = EN_EYE ? busy_word : 32'h0000_0000;
        `REG_DFE_CSR: s_d.rdata = EN_DFE ? busy_word : 32'h0000_0000;
        `REG_DCD_CSR: s_d.rdata = DCD_ON ? busy_word : 32'h0000_0000;
        `REG_AEQ_CSR: s_d.rdata = EN_AEQ ? busy_word : 32'h0000_0000;
        `REG_ATX_CSR: s_d.rdata = EN_PLL_CAL ? busy_word : 32'h0000_0000;
        `REG_STR_CSR: s_d.rdata = STR_ON ? busy_word : 32'h0000_0000;
        `REG_STR_BASE: s_d.rdata = STR_ON ? s_q.img_base : 32'h0000_0000;
        `REG_PLL_CSR: s_d.rdata = EN_PLL_RECONF ? busy_word : 32'h0000_0000;
        default: s_d.rdata = `RDATA_RST;
      endcase
    end
    // Reset held by level restarts power-up calibration
    if (clr) begin
      s_d = '0;
      s_d.st = S_OCAL;
      s_d.init = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.st <= S_OCAL;
      s_q.init <= 1'b1;
      s_q.img_base <= `IMG_BASE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign mgmt_readdata = s_q.rdata;
  // Busy covers every state but idle, including power-up calibration
  assign reconfig_busy = (s_q.st != S_IDLE) || !rst_n_i || clr;
  // Ports tie low when the status option is off; a port list cannot shrink
  assign tx_cal_busy = EN_CAL_STATUS && (!rst_n_i || clr || (s_q.init && s_q.st != S_IDLE));
  assign rx_cal_busy = EN_CAL_STATUS && (!rst_n_i || clr || (s_q.init && s_q.st == S_OCAL));

endmodule : xcvr_reconfig_ctrl

/* File: test/xcvr_reconfig_ctrl_sva.sv */
`timescale 1ns/1ps

module xcvr_reconfig_ctrl_sva
  import xcvr_reconfig_pkg::*;
#(
  parameter int NUM_CH = 1,
  parameter int NUM_PLL = 1,
  localparam int NUM_IF = NUM_CH + NUM_PLL
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic mgmt_rst_reset,
  input wire logic [31:0] img_address,
  input wire logic img_read,
  input wire logic img_waitrequest,
  input wire logic [NUM_IF*70-1:0] lane_update_bus_out,
  input wire logic [NUM_IF*46-1:0] lane_return_bus_in,
  input wire logic reconfig_busy,
  input wire logic tx_cal_busy,
  input wire logic rx_cal_busy,
  input wire logic cal_busy_in
);
  logic act, pend, done, dcd, pll_cal;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n || mgmt_rst_reset);

  // Summary of all lanes; ack of an idle lane is ignored
  always_comb begin
    act = 1'b0;
    pend = 1'b0;
    done = 1'b0;
    dcd = 1'b0;
    pll_cal = 1'b0;
    for (int i = 0; i < NUM_IF; i++) begin
      act |= |lane_update_bus_out[i*70+66+:4];
      pend |= |lane_update_bus_out[i*70+66+:4] && !lane_return_bus_in[i*46+45];
      done |= |lane_update_bus_out[i*70+66+:4] && lane_return_bus_in[i*46+45];
      dcd |= lane_update_bus_out[i*70+66];
      if (i >= NUM_CH) pll_cal |= |lane_update_bus_out[i*70+66+:2];
    end
  end

  chk_fetch_hold: assert property (img_read && img_waitrequest |=> img_read && $stable(img_address))
    else $error("Fetch request moved during stall");
  chk_read_drop: assert property (img_read && !img_waitrequest |=> !img_read)
    else $error("Fetch strobe held after data");
  chk_addr_even: assert property (img_read |-> img_address[0] == 1'b0)
    else $error("Odd fetch byte address");
  chk_cmd_hold: assert property (pend |=> $stable(lane_update_bus_out))
    else $error("Lane command changed before ack");
  chk_ack_release: assert property (done |=> !act)
    else $error("Lane command kept after ack");
  chk_lane_busy: assert property (act |-> reconfig_busy)
    else $error("Lane traffic while not busy");
  chk_tx_busy: assert property (tx_cal_busy |-> reconfig_busy)
    else $error("TX calibration flag without busy");
  chk_rx_in_tx: assert property (rx_cal_busy |-> tx_cal_busy)
    else $error("RX calibration flag outside TX one");
  chk_dcd_defer: assert property ($rose(dcd) |-> !$past(cal_busy_in))
    else $error("Duty-cycle step started while chain busy");
  chk_pll_no_cal: assert property (!pll_cal)
    else $error("Calibration sent to a PLL interface");
  chk_reset_hold: assert property (disable iff (!arst_n) mgmt_rst_reset |=>
    reconfig_busy && tx_cal_busy && rx_cal_busy && lane_update_bus_out == '0 && !img_read)
    else $error("Outputs not held by management reset");

  // Main scenarios reached
  cov_stall: cover property (img_read && img_waitrequest);
  cov_dcd: cover property ($rose(dcd));
  cov_ack: cover property (done && reconfig_busy);
endmodule : xcvr_reconfig_ctrl_sva

bind xcvr_reconfig_ctrl xcvr_reconfig_ctrl_sva #(.NUM_CH(NUM_CH), .NUM_PLL(NUM_PLL)) u_chk (
  .ref_clk(ref_clk), .arst_n(arst_n), .mgmt_rst_reset(mgmt_rst_reset),
  .img_address(img_address), .img_read(img_read), .img_waitrequest(img_waitrequest),
  .lane_update_bus_out(lane_update_bus_out), .lane_return_bus_in(lane_return_bus_in),
  .reconfig_busy(reconfig_busy), .tx_cal_busy(tx_cal_busy), .rx_cal_busy(rx_cal_busy),
  .cal_busy_in(cal_busy_in)
);

/* File: test/phy_far_end.sv */
`timescale 1ns/1ps

module phy_far_end
  import xcvr_reconfig_pkg::*;
#(
  parameter int NUM_IF = 2
) (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic [NUM_IF*70-1:0] lane_update_bus_out,
  output logic [NUM_IF*46-1:0] lane_return_bus_in,
  input wire logic [31:0] img_address,
  input wire logic img_read,
  output logic [15:0] img_readdata,
  output logic img_waitrequest
);
  int cnt [NUM_IF];
  int wcnt;
  logic [15:0] pat = 16'h0001;

  // Wait counters; filler changes each cycle so stale data never matches
  always @(posedge ref_clk) begin
    pat <= pat + 16'h3B1D;
    wcnt <= (img_read && img_waitrequest) ? wcnt + 1 : 0;
    for (int i = 0; i < NUM_IF; i++) cnt[i] <= |lane_update_bus_out[i*70+66+:4] ? cnt[i] + 1 : 0;
  end

  // Answers held back while slow, as a loaded memory or PHY would
  always_comb begin
    lane_ret_t r;
    r = '0;
    img_waitrequest = img_read && (wcnt < (slow ? 3 : 0));
    img_readdata = (img_read && !img_waitrequest) ? img_address[15:0] ^ 16'hC3C3 : pat;
    for (int i = 0; i < NUM_IF; i++) begin
      r = '0;
      r.ack = |lane_update_bus_out[i*70+66+:4] && cnt[i] >= (slow ? 5 : 1);
      r.rdata = r.ack ? lane_update_bus_out[i*70+50+:16] ^ 16'h5A5A : pat;
      lane_return_bus_in[i*46+:46] = r;
    end
  end
endmodule : phy_far_end

/* File: test/testbench.sv */
`timescale 1ns/1ps

module testbench;
  import xcvr_reconfig_pkg::*;
  localparam int NCH = 1;
  localparam int NIF = 2;
  localparam int IMGW = 8;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic mgmt_rst_reset = 1'b0;
  logic [6:0] mgmt_address = 7'h00;
  logic [31:0] mgmt_writedata = 32'h0;
  logic [31:0] mgmt_readdata, img_address, base_e, rv;
  logic mgmt_write = 1'b0;
  logic mgmt_read = 1'b0;
  logic img_read, img_waitrequest, reconfig_busy, tx_cal_busy, rx_cal_busy;
  logic [15:0] img_readdata;
  logic [NIF*70-1:0] lane_update_bus_out;
  logic [NIF*46-1:0] lane_return_bus_in;
  logic cal_busy_in = 1'b1;
  logic slow = 1'b0;
  logic [NIF-1:0] prv = '0;
  logic [39:0] wr_q [$];
  int errors, compares, n_ocal, n_dcd, n_rd, n_img, n_txhi;

  always #10 ref_clk = ~ref_clk;

  xcvr_reconfig_ctrl #(.IMG_WORDS(16'h0008)) u_xcvr_reconfig_ctrl (
    .ref_clk(ref_clk), .arst_n(arst_n), .mgmt_rst_reset(mgmt_rst_reset),
    .mgmt_address(mgmt_address), .mgmt_writedata(mgmt_writedata), .mgmt_readdata(mgmt_readdata),
    .mgmt_write(mgmt_write), .mgmt_read(mgmt_read), .img_address(img_address), .img_read(img_read),
    .img_readdata(img_readdata), .img_waitrequest(img_waitrequest),
    .lane_update_bus_out(lane_update_bus_out), .lane_return_bus_in(lane_return_bus_in),
    .reconfig_busy(reconfig_busy), .tx_cal_busy(tx_cal_busy), .rx_cal_busy(rx_cal_busy),
    .cal_busy_in(cal_busy_in));

  phy_far_end #(.NUM_IF(NIF)) u_phy_far_end (
    .ref_clk(ref_clk), .slow(slow), .lane_update_bus_out(lane_update_bus_out),
    .lane_return_bus_in(lane_return_bus_in), .img_address(img_address), .img_read(img_read),
    .img_readdata(img_readdata), .img_waitrequest(img_waitrequest));

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Management cycles, one strobe cycle each
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    mgmt_address <= a;
    mgmt_writedata <= d;
    mgmt_write <= 1'b1;
    @(posedge ref_clk);
    mgmt_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] a);
    @(posedge ref_clk);
    mgmt_address <= a;
    mgmt_read <= 1'b1;
    @(posedge ref_clk);
    mgmt_read <= 1'b0;
    @(posedge ref_clk);
    #1 rv = mgmt_readdata;
  endtask : rd

  // Busy needs a cycle to rise, so skip two edges before polling
  task automatic wait_idle;
    int k;
    repeat (2) @(posedge ref_clk);
    for (k = 0; k < 4000; k++) begin
      #1;
      if (reconfig_busy === 1'b0) break;
      @(posedge ref_clk);
    end
    if (k == 4000) begin
      errors++;
      $display("Error at %0t: busy wait expired", $time);
      report_and_stop();
    end
  endtask : wait_idle

  // Bench model: counts new lane commands and checks fetch addresses
  always @(posedge ref_clk) begin : mon
    lane_cmd_t c;
    n_txhi += int'(tx_cal_busy === 1'b1);
    if (img_read === 1'b1 && img_waitrequest === 1'b0) begin
      chk(img_address, base_e + 32'(2 * n_img));
      n_img++;
    end
    for (int i = 0; i < NIF; i++) begin
      c = lane_cmd_t'(lane_update_bus_out[i*70+:70]);
      if ((c.wr | c.rd | c.ocal | c.dcd) === 1'b1 && prv[i] === 1'b0) begin
        n_ocal += int'(c.ocal);
        n_dcd += int'(c.dcd);
        n_rd += int'(c.rd);
        if (c.wr) wr_q.push_back({8'(i), c.addr, c.wdata});
      end
      prv[i] = c.wr | c.rd | c.ocal | c.dcd;
    end
  end

  initial begin
    logic [31:0] a, b, d;
    int n0, n1;
    void'($urandom(42));
    repeat (4) @(posedge ref_clk);
    #1 chk({reconfig_busy, tx_cal_busy, rx_cal_busy}, 3'b111);
    @(posedge ref_clk);
    arst_n <= 1'b1;
    // Power-up with the chain partner still calibrating
    repeat (60) @(posedge ref_clk);
    #1 chk(n_ocal, NCH);
    chk(n_dcd, 0);
    chk({reconfig_busy, tx_cal_busy, rx_cal_busy}, 3'b110);
    @(posedge ref_clk);
    cal_busy_in <= 1'b0;
    wait_idle();
    chk(n_dcd, NCH);
    chk({tx_cal_busy, rx_cal_busy}, 2'b00);
    $display("power_up done");
    // Random field values read back at word addresses
    for (int k = 0; k < 4; k++) begin
      a = $urandom & 32'h3FF;
      b = $urandom & 32'h3F;
      d = $urandom & 32'h7F;
      wr(7'h08, a);
      wr(7'h0B, b);
      wr(7'h0C, d);
      rd(7'h08);
      chk(rv, a);
      rd(7'h0B);
      chk(rv, b);
      rd(7'h0C);
      chk(rv, d);
    end
    rd(7'h7C);
    chk(rv, 0);
    rd(7'h12);
    chk(rv, 0);
    $display("registers done");
    // Second trigger lands while busy and must be dropped
    slow <= 1'b1;
    wr(7'h08, 32'h1);
    wr(7'h0A, 32'h1);
    wr(7'h0A, 32'h1);
    rd(7'h0A);
    chk(rv[8], 1'b1);
    wait_idle();
    chk(wr_q.size(), 1);
    chk(wr_q.pop_front(), {8'h01, 16'(b), 16'(d)});
    rd(7'h0A);
    chk(rv[9:8], 2'b00);
    wr(7'h08, NIF);
    wr(7'h0A, 32'h1);
    rd(7'h0A);
    chk(rv[9:8], 2'b10);
    wr(7'h08, 32'h0);
    wr(7'h0A, 32'h2);
    wait_idle();
    chk(wr_q.size(), 0);
    chk(n_rd, 1);
    // Far end answers a read with its address pattern
    rd(7'h0C);
    chk(rv, (b ^ 32'h5A) & 32'h7F);
    $display("pma done");
    // Image stream from a random even base with a stalling memory
    base_e = $urandom & 32'h00FF_FFFE;
    n_img = 0;
    wr(7'h3C, base_e);
    wr(7'h08, 32'h1);
    wr(7'h3A, 32'h1);
    wait_idle();
    chk(n_img, IMGW);
    for (int k = 0; k < IMGW / 2; k++) begin
      a = base_e + 32'(4 * k);
      chk(wr_q.pop_front(), {8'h01, a[15:0] ^ 16'hC3C3, (a[15:0] + 16'h2) ^ 16'hC3C3});
    end
    $display("stream done");
    // Manual duty-cycle rerun keeps the TX calibration flag low
    n0 = n_txhi;
    n1 = n_dcd;
    wr(7'h22, 32'h1);
    wait_idle();
    chk(n_dcd, n1 + NCH);
    chk(n_txhi, n0);
    // Management reset restarts offset cancellation
    @(posedge ref_clk);
    mgmt_rst_reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk({reconfig_busy, tx_cal_busy, rx_cal_busy, |lane_update_bus_out}, 4'hE);
    n0 = n_ocal;
    @(posedge ref_clk);
    mgmt_rst_reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk(rx_cal_busy, 1'b1);
    wait_idle();
    chk(n_ocal, n0 + NCH);
    $display("reset done");
    report_and_stop();
  end
endmodule : testbench
